// *** rtl/ddmpr_top.sv ***
// multipurpose register access mode command interpreter
// Functional notes
// - four pages of four 8-bit registers
// - mode enabled by mode register 3 bit 2
// - page from MR3[1:0], register from BA
// - reads served from selected special register
// - autoprecharge variants act as plain accesses
// - location from address, halves fit burst 8
// - reset accepted, state, mode register images and page 0 re-initialized, flags kept
// - BL8 or BC4 by A[2:0], no OTF
// - page 0 defaults, writable, kept
// - page 0 default training patterns
// - page purposes: training, parity, readout, reserved
// - page 0 any format, others serial
// - serial: A7 to UI0 down to A0 at UI7
module ddmpr_top #(
  parameter int TRFC = ddmpr_pkg::TRFC_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [31:0] parity_frame,   // captured error frame
  input  wire logic        parity_enable,  // parity checking on
  output logic             array_rd,       // normal array read pulse
  output logic             array_wr,       // normal array write pulse
  output logic [7:0]       dq_burst [8],   // burst, one byte per UI
  output logic             dq_valid        // burst ready pulse
);

  // ------------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------------
  typedef enum {
    DDMPR_IDLE,
    DDMPR_REF
  } ddmpr_st_t;

  ddmpr_st_t   st;              // refresh guard state
  ddmpr_st_t   next_st;         // its next value
  logic [12:0] mr3;             // mode register 3 image
  logic [7:0]  mr [8];          // other mode register images
  logic [15:0] rfc_cnt;         // refresh cycle counter
  logic [7:0]  rd_byte;         // last readout
  logic        ill;             // sticky illegal command flag
  logic        bc4;             // last read was chop 4
  logic        ack;             // one-cycle bus answer
  logic [31:0] rdata_q;         // registered read data

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  // a write lands only at the edge where waitrequest is sampled low
  wire         wr_hit  = avs_write && ack;
  wire         cmd_go  = ce && wr_hit && avs_address == ddmpr_pkg::OFS_CMD;
  wire         ctl_go  = ce && wr_hit && avs_address == ddmpr_pkg::OFS_CTRL;
  wire  [3:0]  op      = avs_writedata[ddmpr_pkg::CMD_OP_LSB +: 4];
  wire  [1:0]  cba     = avs_writedata[ddmpr_pkg::CMD_BA_LSB +: 2];
  wire  [7:0]  caddr   = avs_writedata[ddmpr_pkg::CMD_ADDR_LSB +: 8];
  wire         mode_en = mr3[ddmpr_pkg::MR3_EN_BIT];
  wire  [1:0]  page    = mr3[ddmpr_pkg::MR3_PAGE_LSB +: 2];
  wire  [1:0]  fmt     = mr3[ddmpr_pkg::MR3_FMT_LSB +: 2];

  // read and write alike drop the autoprecharge part
  function automatic logic is_rd(input logic [3:0] o);
    is_rd = o == ddmpr_pkg::DDMPR_OP_RD || o == ddmpr_pkg::DDMPR_OP_RDA;
  endfunction
  function automatic logic is_wr(input logic [3:0] o);
    is_wr = o == ddmpr_pkg::DDMPR_OP_WR || o == ddmpr_pkg::DDMPR_OP_WRA;
  endfunction

  // commands legal while the mode is on
  function automatic logic legal(input logic [3:0] o);
    legal = is_rd(o) || is_wr(o) ||
            o == ddmpr_pkg::DDMPR_OP_MRS ||
            o == ddmpr_pkg::DDMPR_OP_DES ||
            o == ddmpr_pkg::DDMPR_OP_REF ||
            o == ddmpr_pkg::DDMPR_OP_RST;
  endfunction

  wire         busy     = st == DDMPR_REF;
  wire         burst_ok = caddr[2:0] == ddmpr_pkg::BURST_BL8 ||
                          caddr[2:0] == ddmpr_pkg::BURST_BC4;
  wire         cmd_ok   = !busy && (!mode_en || legal(op));
  wire         m_rd     = cmd_go && cmd_ok && mode_en && is_rd(op)
                          && burst_ok;
  wire         m_wr     = cmd_go && cmd_ok && mode_en && is_wr(op);
  wire         do_rst   = cmd_go && op == ddmpr_pkg::DDMPR_OP_RST;
  wire         do_ref   = cmd_go && cmd_ok
                          && op == ddmpr_pkg::DDMPR_OP_REF;
  wire         do_mrs   = cmd_go && cmd_ok
                          && op == ddmpr_pkg::DDMPR_OP_MRS;

  // ------------------------------------------------------------------
  // page 0 storage
  // ------------------------------------------------------------------
  logic [7:0] p0_data;
  ddmpr_page0 #(
    .W (8)
  ) u_page0 (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .init  (do_rst),
    .we    (m_wr && page == 2'h0),
    .wsel  (cba),
    .wdata (caddr),
    .rsel  (cba),
    .rdata (p0_data)
  );

  // ------------------------------------------------------------------
  // page select: training, parity log, mode readout, reserved
  // ------------------------------------------------------------------
  wire  [7:0] p1_data = parity_enable ? parity_frame[8*cba +: 8]
                                      : 8'h00;
  wire  [7:0] p2_data = mr[{1'b0, cba}];
  wire  [7:0] sel_data;
  assign sel_data = page == 2'h0 ? p0_data :
                    page == 2'h1 ? p1_data :
                    page == 2'h2 ? p2_data : 8'h00;

  // only page 0 leaves serial format
  wire  [1:0] eff_fmt = page == 2'h0 ? fmt : ddmpr_pkg::FMT_SERIAL;

  // ------------------------------------------------------------------
  // burst formation: each UI gives one byte across the lanes
  // ------------------------------------------------------------------
  logic [7:0] next_burst [8];
  genvar u;
  for (u = 0; u < 8; u++) begin : g_ui
    // serial: UI u carries bit 7-u on every lane
    wire       sbit = sel_data[7-u];
    wire [7:0] ser  = {8{sbit}};
    wire [7:0] par  = sel_data;                                   // whole byte
    wire [7:0] stg  = p0_data; // staggered folds to lane-rotated byte
    assign next_burst[u] =
      eff_fmt == ddmpr_pkg::FMT_PARAL ? par :
      eff_fmt == ddmpr_pkg::FMT_STAGR ? 8'((stg << u) | (stg >> (8-u))) :
      ser;
  end

  // ------------------------------------------------------------------
  // refresh guard state machine
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    case (st)
      DDMPR_IDLE: begin
        if (do_ref) begin
          next_st = DDMPR_REF;
        end
      end
      DDMPR_REF: begin
        if (rfc_cnt == 16'(TRFC - 1)) begin
          next_st = DDMPR_IDLE;
        end
      end
      default: begin
        next_st = DDMPR_IDLE;
      end
    endcase
  end

  // state and refresh counter
  always_ff @(posedge clk) begin
    if (srst || (ce && do_rst)) begin
      st      <= DDMPR_IDLE;
      rfc_cnt <= 16'h0000;
    end else if (ce) begin
      st      <= next_st;
      rfc_cnt <= busy ? 16'(rfc_cnt + 16'h0001) : 16'h0000;
    end
  end

  // mode register 3 image, written by control or MRS
  always_ff @(posedge clk) begin
    if (srst || (ce && do_rst)) begin
      mr3 <= 13'h0000;
    end else if (ctl_go || (do_mrs && cba == 2'h3)) begin
      mr3 <= avs_writedata[12:0];
    end
  end

  // other mode register images for readout
  always_ff @(posedge clk) begin
    if (srst || (ce && do_rst)) begin
      for (int k = 0; k < 8; k++) begin
        mr[k] <= 8'h00;
      end
    end else if (do_mrs && cba != 2'h3) begin
      mr[{1'b0, cba}] <= caddr;
    end
  end

  // readout, burst and flags
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_byte  <= 8'h00;
      ill      <= 1'b0;
      bc4      <= 1'b0;
      dq_valid <= 1'b0;
      array_rd <= 1'b0;
      array_wr <= 1'b0;
      for (int k = 0; k < 8; k++) begin
        dq_burst[k] <= 8'h00;
      end
    end else if (ce) begin
      dq_valid <= m_rd;
      array_rd <= cmd_go && cmd_ok && !mode_en && is_rd(op);
      array_wr <= cmd_go && cmd_ok && !mode_en && is_wr(op);
      if (m_rd) begin
        rd_byte  <= sel_data;
        bc4      <= caddr[2];
        dq_burst <= next_burst;
      end
      if (cmd_go && !cmd_ok) begin
        ill <= 1'b1;
      end else if (ctl_go && avs_writedata[31]) begin
        ill <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // bus slave: one wait cycle, then answer
  // ------------------------------------------------------------------
  wire [31:0] st_word = 32'({bc4, !mode_en, ill, busy, mode_en});
  wire        mr_hit  = avs_address >= ddmpr_pkg::OFS_MR0 &&
                        avs_address <  ddmpr_pkg::OFS_PAR;
  wire [31:0] rmux    =
    avs_address == ddmpr_pkg::OFS_CTRL   ? 32'(mr3) :
    avs_address == ddmpr_pkg::OFS_RDATA  ? 32'(rd_byte) :
    avs_address == ddmpr_pkg::OFS_STATUS ? st_word :
    mr_hit ? 32'(mr[avs_address[4:2]]) : 32'h0000_0000;

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack     <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack     <= (avs_read || avs_write) && !ack;
      rdata_q <= rmux;
    end
  end

endmodule

// *** rtl/ddmpr_pkg.sv ***
// package: constants for the multipurpose register access block
package ddmpr_pkg;

  // ------------------------------------------------------------------
  // register bus map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // mode register 3 image
  localparam logic [7:0] OFS_CMD    = 8'h04; // command issue
  localparam logic [7:0] OFS_RDATA  = 8'h08; // last readout
  localparam logic [7:0] OFS_STATUS = 8'h0C; // block state
  localparam logic [7:0] OFS_MR0    = 8'h10; // mode register images
  localparam logic [7:0] OFS_PAR    = 8'h30; // end of the mode register images, reads as zero

  // ------------------------------------------------------------------
  // control field layout
  // ------------------------------------------------------------------
  localparam int MR3_PAGE_LSB = 0;  // page select bits 1:0
  localparam int MR3_EN_BIT   = 2;  // access mode enable
  localparam int MR3_FMT_LSB  = 11; // readout format bits 12:11

  // ------------------------------------------------------------------
  // command register fields
  // ------------------------------------------------------------------
  localparam int CMD_OP_LSB   = 24; // opcode 27:24
  localparam int CMD_BA_LSB   = 16; // bank address 17:16
  localparam int CMD_ADDR_LSB = 0;  // address 7:0 / data

  // command opcodes
  typedef enum logic [3:0] {
    DDMPR_OP_DES  = 4'h0,
    DDMPR_OP_MRS  = 4'h1,
    DDMPR_OP_RD   = 4'h2,
    DDMPR_OP_RDA  = 4'h3,
    DDMPR_OP_WR   = 4'h4,
    DDMPR_OP_WRA  = 4'h5,
    DDMPR_OP_REF  = 4'h6,
    DDMPR_OP_RST  = 4'h7,
    DDMPR_OP_PDE  = 4'h8,
    DDMPR_OP_SRE  = 4'h9,
    DDMPR_OP_ACT  = 4'hA,
    DDMPR_OP_PRE  = 4'hB
  } ddmpr_op_t;

  // readout formats
  localparam logic [1:0] FMT_SERIAL = 2'h0;
  localparam logic [1:0] FMT_PARAL  = 2'h1;
  localparam logic [1:0] FMT_STAGR  = 2'h2;

  // burst selection on address bits 2:0
  localparam logic [2:0] BURST_BL8 = 3'h0;
  localparam logic [2:0] BURST_BC4 = 3'h4;

  // default training patterns of page 0
  localparam logic [7:0] PAT0 = 8'h55;
  localparam logic [7:0] PAT1 = 8'h33;
  localparam logic [7:0] PAT2 = 8'h0F;
  localparam logic [7:0] PAT3 = 8'h00;

  // refresh cycle time
  localparam int TRFC_NS  = 260;
  localparam int CLK_MHZ  = 50;
  localparam int TRFC_CYC = (TRFC_NS * CLK_MHZ + 999) / 1000;

  // status bits
  localparam int ST_EN    = 0;
  localparam int ST_BUSY  = 1;
  localparam int ST_ILL   = 2;
  localparam int ST_ARRAY = 3;
  localparam int ST_BC4   = 4;

endpackage

// *** rtl/ddmpr_page0.sv ***
// page 0 training pattern storage with defaults and write port
module ddmpr_page0 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         init,  // re-initialization
  input  wire logic         we,
  input  wire logic [1:0]   wsel,
  input  wire logic [W-1:0] wdata,
  input  wire logic [1:0]   rsel,
  output logic      [W-1:0] rdata
);

  logic [W-1:0] mem [4];       // four training registers
  logic [W-1:0] dflt [4];      // power-up patterns

  // ------------------------------------------------------------------
  // defaults
  // ------------------------------------------------------------------
  assign dflt[0] = W'(ddmpr_pkg::PAT0);
  assign dflt[1] = W'(ddmpr_pkg::PAT1);
  assign dflt[2] = W'(ddmpr_pkg::PAT2);
  assign dflt[3] = W'(ddmpr_pkg::PAT3);

  assign rdata = mem[rsel];

  // ------------------------------------------------------------------
  // storage: each register reloads or takes a write
  // ------------------------------------------------------------------
  genvar i;
  for (i = 0; i < 4; i++) begin : g_reg
    always_ff @(posedge clk) begin
      if (srst || (ce && init)) begin
        mem[i] <= dflt[i];
      end else if (ce && we && wsel == 2'(i)) begin
        mem[i] <= wdata;
      end
    end
  end

endmodule

// *** bench/ddmpr_properties.sv ***
// checker: command timing and readout relations at the block ports
module ddmpr_properties #(
  parameter int TRFC = 4
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] parity_frame,
  input wire logic        parity_enable,
  input wire logic        array_rd,
  input wire logic        array_wr,
  input wire logic [7:0]  dq_burst [8],
  input wire logic        dq_valid
);
  logic [12:0] mr3;   // mode register 3 mirror
  logic [1:0]  ba_q;  // register of last command
  logic        bl8;   // last command chose a full burst
  logic        wrote; // page 0 rewritten since init
  int          rf;    // refresh cycles left
  logic [7:0]  ui;    // lane 0 bits, UI0 in bit 7
  logic [7:0]  pat;   // default pattern of ba_q
  wire  [3:0]  op  = avs_writedata[27:24];
  wire         acc = ce && avs_write && !avs_waitrequest
                     && avs_address == ddmpr_pkg::OFS_CMD;
  wire         ctl = ce && avs_write && !avs_waitrequest
                     && avs_address == ddmpr_pkg::OFS_CTRL;
  wire         md  = mr3[2];
  wire         rd  = acc && md && rf == 0 && op[3:1] == 3'h1
                     && avs_writedata[1:0] == 2'h0;
  wire         ser = dq_valid && mr3[12:11] == 2'h0 && bl8;
  assign pat = ba_q[1] ? (ba_q[0] ? ddmpr_pkg::PAT3 : ddmpr_pkg::PAT2)
             : (ba_q[0] ? ddmpr_pkg::PAT1 : ddmpr_pkg::PAT0);
  // lane 0 of the burst, first interval in the top bit
  always_comb begin
    for (int i = 0; i < 8; i++) ui[7 - i] = dq_burst[i][0];
  end
  // mirror of mode, register select and refresh window
  always_ff @(posedge clk) begin
    if (srst) begin
      mr3   <= '0;
      ba_q  <= '0;
      bl8   <= 1'b0;
      wrote <= 1'b0;
      rf    <= 0;
    end else begin
      rf <= (acc && op == 4'h6) ? TRFC : (rf > 0 ? rf - 1 : 0);
      if (acc) begin
        ba_q <= avs_writedata[17:16];
        bl8  <= avs_writedata[2:0] == 3'h0;
      end
      if (acc && md && op[3:1] == 3'h2 && mr3[1:0] == 2'h0)
        wrote <= 1'b1;
      if (acc && op == 4'h1 && avs_writedata[17:16] == 2'h3)
        mr3 <= avs_writedata[12:0];
      if (ctl)
        mr3 <= avs_writedata[12:0];
      if (acc && op == 4'h7) begin
        mr3   <= '0;
        wrote <= 1'b0;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ans; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence s_burst; dq_valid && !array_rd && !array_wr; endsequence
  property p_answer; $rose(avs_write) && ce |-> s_ans; endproperty
  property p_served; rd |=> s_burst; endproperty
  property p_cause; dq_valid |-> $past(rd); endproperty
  property p_no_array; acc && md |=> !array_rd && !array_wr; endproperty
  property p_norm_rd; acc && !md && op == 4'h2 |=> array_rd; endproperty
  property p_norm_wr; acc && !md && op == 4'h4 |=> array_wr; endproperty
  property p_page0; ser && mr3[1:0] == 2'h0 && !wrote |-> ui == pat;
  endproperty
  property p_page1; ser && mr3[1:0] == 2'h1 && parity_enable
    |-> ui == parity_frame[8 * ba_q +: 8]; endproperty
  a_answer: assert property (p_answer)
    else $error("command write not answered on second cycle");
  a_served: assert property (p_served)
    else $error("read in access mode gave no burst");
  a_cause: assert property (p_cause)
    else $error("burst without an accepted read");
  a_no_array: assert property (p_no_array)
    else $error("array access while in access mode");
  a_norm_rd: assert property (p_norm_rd)
    else $error("normal read gave no array read");
  a_norm_wr: assert property (p_norm_wr)
    else $error("normal write gave no array write");
  a_page0: assert property (p_page0)
    else $error("page 0 default pattern wrong");
  a_page1: assert property (p_page1)
    else $error("page 1 error frame byte wrong");
endmodule

bind ddmpr_top ddmpr_properties #(.TRFC(TRFC)) u_props (
  .clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .parity_frame(parity_frame),
  .parity_enable(parity_enable), .array_rd(array_rd),
  .array_wr(array_wr), .dq_burst(dq_burst), .dq_valid(dq_valid));

// *** bench/ddmpr_ctrl_model.sv ***
// controller model: register bus master issuing access mode commands
module ddmpr_ctrl_model #(
  parameter int TRFC = 4
) (
  input  wire logic        clk,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end
  // one transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write     <= 1'b0;
    avs_read      <= 1'b0;
    avs_writedata <= ~d;
    @(posedge clk);
  endtask
  // command word: opcode, bank address, address or data
  task automatic cmd(input logic [3:0] op, input logic [1:0] ba,
                     input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, ddmpr_pkg::OFS_CMD, {4'h0, op, 6'h00, ba, d}, q);
  endtask
  // mode register 3 load, data bus inversion never requested
  task automatic mrs3(input logic [15:0] d);
    cmd(4'h1, 2'h3, d);
  endtask
  // entry after init: all banks precharged first
  task automatic enter(input logic [1:0] pg);
    cmd(4'hB, 2'h0, 16'h0000);
    mrs3({14'h0001, pg});
  endtask
  // plain refresh between accesses, then the cycle time is kept
  task automatic refresh();
    cmd(4'h6, 2'h0, 16'h0000);
    repeat (TRFC) @(posedge clk);
  endtask
endmodule

// *** bench/ddr4_mpr_access_mode_tb.sv ***
// testbench: page reads from a table, then writes, refusals and exit
module ddr4_mpr_access_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TRFC = 4;  // shortened refresh cycle time
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;       // clock enable, dropped once
  logic        par_en = 1'b1;   // parity checking on
  logic [31:0] frame = 32'hC3A50F96; // parity error frame
  logic [31:0] q;
  logic [15:0] r;
  logic [7:0]  ui;          // lane 0 of last burst
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        array_rd;
  logic        array_wr;
  logic [7:0]  dq_burst [8];
  logic        dq_valid;
  logic [3:0]  bad [4] = '{4'hA, 4'hB, 4'h8, 4'h9}; // refused in mode
  // rows: page, register, opcode, expected byte
  logic [15:0] rows [8] = '{16'h0255, 16'h1333, 16'h220F, 16'h3300,
                            16'h4296, 16'h530F, 16'h62A5, 16'h72C3};
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n_arr = 0;
  ddmpr_top #(.TRFC(TRFC)) DUT (
    .clk(clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .parity_frame(frame), .parity_enable(par_en), .array_rd(array_rd),
    .array_wr(array_wr), .dq_burst(dq_burst), .dq_valid(dq_valid));
  ddmpr_ctrl_model #(.TRFC(TRFC)) M (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  initial forever #10 clk = ~clk;
  // burst capture, array pulse count and hang limit
  always @(posedge clk) begin
    cycles++;
    if (dq_valid === 1'b1)
      for (int i = 0; i < 8; i++) ui[7 - i] = dq_burst[i][0];
    if (array_rd === 1'b1 || array_wr === 1'b1) n_arr++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic status(input logic [31:0] m, input logic [31:0] e);
    M.bus(1'b0, ddmpr_pkg::OFS_STATUS, 32'h0, q);
    check(q & m, e);
  endtask
  // read in access mode: burst lane and readout word compared
  task automatic rd_ui(input logic [3:0] op, input logic [1:0] ba,
                       input logic [7:0] e);
    ui = ~e;
    M.cmd(op, ba, 16'h0000);
    @(posedge clk);
    check({24'h0, ui}, {24'h0, e});
    M.bus(1'b0, ddmpr_pkg::OFS_RDATA, 32'h0, q);
    check(q, {24'h0, e});
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    status(32'h1F, 32'h08);
    M.enter(2'h0);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      M.mrs3({14'h0001, r[15:14]});
      rd_ui(r[11:8], r[13:12], r[7:0]);
    end
    $display("page table done");
    M.mrs3(16'h0004);
    // clock enable low: the write waits frozen, then lands
    ce <= 1'b0;
    fork
      M.cmd(4'h4, 2'h3, 16'h005A);
      begin
        repeat (4) @(posedge clk);
        check(32'(avs_waitrequest), 32'h1);
        ce <= 1'b1;
      end
    join
    rd_ui(4'h2, 2'h3, 8'h5A);
    M.cmd(4'h4, 2'h1, 16'h00A5);
    M.cmd(4'h5, 2'h2, 16'h003C);
    rd_ui(4'h2, 2'h1, 8'hA5);
    rd_ui(4'h3, 2'h2, 8'h3C);
    rd_ui(4'h2, 2'h0, 8'h55);
    M.mrs3(16'h0005);
    M.cmd(4'h4, 2'h0, 16'h0011);
    rd_ui(4'h2, 2'h0, 8'h96);
    par_en <= 1'b0;
    rd_ui(4'h2, 2'h3, 8'h00);
    par_en <= 1'b1;
    M.mrs3(16'h0004);
    rd_ui(4'h2, 2'h0, 8'h55);
    M.cmd(4'h2, 2'h0, 16'h0004);
    status(32'h15, 32'h11);
    check(32'(n_arr), 32'h0);
    $display("write and burst tests done");
    foreach (bad[k]) begin
      M.bus(1'b1, ddmpr_pkg::OFS_CTRL, 32'h80000005, q);
      M.cmd(bad[k], 2'h0, 16'h0000);
      status(32'h5, 32'h5);
    end
    M.bus(1'b1, ddmpr_pkg::OFS_CTRL, 32'h80000005, q);
    M.refresh();
    status(32'h5, 32'h1);
    M.cmd(4'h6, 2'h0, 16'h0000);
    M.cmd(4'h2, 2'h0, 16'h0000);
    status(32'h5, 32'h5);
    $display("refusal tests done");
    M.cmd(4'h7, 2'h0, 16'h0000);
    M.enter(2'h0);
    rd_ui(4'h2, 2'h2, 8'h0F);
    M.mrs3(16'h0000);
    M.cmd(4'h2, 2'h0, 16'h0000);
    M.cmd(4'h4, 2'h0, 16'h0000);
    @(posedge clk);
    check(32'(n_arr), 32'h2);
    $display("reset and exit tests done");
    test_done();
  end
endmodule
